// [hdl/stc_sample_path_test.v]
// Sample path test logic: sequence checker, constant test value and decoder shuffle selects.
// Assumes the register port and the sample stream run on clk; no input crosses a clock domain.
// Reset is synchronous and is taken whatever the clock enable shows.
// Pass flags and mismatch counters live in the two lane instances; this level maps them.
//
// Behaviour
// - Bit 7 of the checker control register reads 1 while the imaginary stream matches and 0 after a mismatch.
// - Bit 6 of the checker control register reads 1 while the real stream matches and 0 after a mismatch.
// - Bit 4 makes the imaginary checker expect inverted data when 1, and it resets to 1.
// - Bit 3 makes the real checker expect inverted data when 1, and it resets to 0.
// - Bit 0 enables the checker and bit 2 picks the 7-bit or 15-bit polynomial the source must send.
// - Each channel has an 8-bit read-only mismatch counter, and writing 1 to bit 1 clears both.
// - A 16-bit constant held in two registers replaces the sample data while its enable bit 1 is set.
// - The top decoder segment is thermometer coded when decoder bit 2 is 0 and shuffled when it is 1.
// - The middle decoder segment is thermometer coded when decoder bit 1 is 0 and shuffled when it is 1.
// - The bottom decoder segment is thermometer coded when decoder bit 0 is 0 and shuffled when it is 1.
`default_nettype none
`include "stc_defines.vh"

module stc_sample_path_test (
	// Clock, reset and enable
	input wire clk,
	input wire nrst,
	input wire ce,
	// Register port
	input wire regWrite,
	input wire regRead,
	input wire [11:0] regAddr,
	input wire [7:0] regWdata,
	output reg [7:0] regRdata,
	output reg regRvalid,
	// Incoming samples
	input wire sampleValid,
	input wire [15:0] realSample,
	input wire [15:0] imagSample,
	// Outgoing samples
	output reg outValid,
	output reg [15:0] outReal,
	output reg [15:0] outImag,
	// Decoder segment selects
	output reg msbShuffle,
	output reg midShuffle,
	output reg lsbShuffle,
	// Checker state
	output reg checkerActive
);

	// Write strobe decode for one offset
	function stc_hit;
		input wr;
		input [11:0] addr;
		input [11:0] off;
		begin
			stc_hit = wr & (addr == off);
		end
	endfunction

	// Control register fields
	reg checkerEnable;
	reg polynomialSelect;
	reg counterClear;
	reg realExpectInverted;
	reg imagExpectInverted;

	// Constant test value and its enable
	reg [7:0] constantValueHigh;
	reg [7:0] constantValueLow;
	reg constantTestEnable;
	reg digTestReserved;

	// Decoder shuffle control, reserved bits kept as written
	reg [7:0] decoderShuffleControl;

	// Lane results
	wire realPassFlag;
	wire imagPassFlag;
	wire [7:0] realMismatchCount;
	wire [7:0] imagMismatchCount;

	// Write strobes
	wire wrSeqCtrl;
	wire wrConstHi;
	wire wrConstLo;
	wire wrDigTest;
	wire wrDecode;

	// Assembled read values
	wire [7:0] seqCtrlRead;
	wire [7:0] digTestRead;
	wire [15:0] constantTestValue;
	reg [7:0] next_regRdata;

	// Strobes for each writable offset
	assign wrSeqCtrl = stc_hit(regWrite, regAddr, `STC_OFF_SEQ_CTRL);
	assign wrConstHi = stc_hit(regWrite, regAddr, `STC_OFF_CONST_HI);
	assign wrConstLo = stc_hit(regWrite, regAddr, `STC_OFF_CONST_LO);
	assign wrDigTest = stc_hit(regWrite, regAddr, `STC_OFF_DIGITAL_TEST_CONTROL);
	assign wrDecode = stc_hit(regWrite, regAddr, `STC_OFF_DECODE);

	// Checker control register, pass flags read back live
	assign seqCtrlRead = {
		imagPassFlag,
		realPassFlag,
		1'b0,
		imagExpectInverted,
		realExpectInverted,
		polynomialSelect,
		counterClear,
		checkerEnable
	};

	// Digital test control register, upper bits reserved as zero
	assign digTestRead = {6'h00, constantTestEnable, digTestReserved};

	// The constant spans two registers, high byte first
	assign constantTestValue = {constantValueHigh, constantValueLow};

	// Checker control writes; pass flags are read only
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			checkerEnable <= 1'b0;
			polynomialSelect <= 1'b0;
			counterClear <= 1'b0;
			realExpectInverted <= `STC_RST_REAL_INV;
			imagExpectInverted <= `STC_RST_IMAG_INV;
		end
		else if (ce && wrSeqCtrl)
		begin
			// Whole-byte write; bits 7 to 5 have no storage
			checkerEnable <= regWdata[`STC_BIT_CHK_EN];
			polynomialSelect <= regWdata[`STC_BIT_POLY_SEL];
			counterClear <= regWdata[`STC_BIT_CNT_CLEAR];
			realExpectInverted <= regWdata[`STC_BIT_REAL_INV];
			imagExpectInverted <= regWdata[`STC_BIT_IMAG_INV];
		end
	end

	// Constant test value bytes
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			constantValueHigh <= `STC_RST_BYTE;
			constantValueLow <= `STC_RST_BYTE;
		end
		else if (ce)
		begin
			// Each byte applies as written, with no interlock between the halves
			if (wrConstHi)
				constantValueHigh <= regWdata;
			if (wrConstLo)
				constantValueLow <= regWdata;
		end
	end

	// Digital test control and decoder shuffle control
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			constantTestEnable <= 1'b0;
			digTestReserved <= 1'b0;
			decoderShuffleControl <= `STC_RST_BYTE;
		end
		else if (ce)
		begin
			if (wrDigTest)
			begin
				constantTestEnable <= regWdata[`STC_BIT_CONST_EN];
				digTestReserved <= regWdata[`STC_BIT_DIG_RSVD];
			end
			// Reserved decoder bits are stored and read back as written
			if (wrDecode)
				decoderShuffleControl <= regWdata;
		end
	end

	// Both lanes share enable, polynomial and clear; only the inversion differs
	// Real channel checker
	stc_sequence_checker_control_lane realLane (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.enable(checkerEnable),
		.polySel(polynomialSelect),
		.expectInv(realExpectInverted),
		.clearCount(counterClear),
		.sampleValid(sampleValid),
		.sample(realSample),
		.passFlag(realPassFlag),
		.mismatchCount(realMismatchCount)
	);

	// Imaginary channel checker
	stc_sequence_checker_control_lane imagLane (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.enable(checkerEnable),
		.polySel(polynomialSelect),
		.expectInv(imagExpectInverted),
		.clearCount(counterClear),
		.sampleValid(sampleValid),
		.sample(imagSample),
		.passFlag(imagPassFlag),
		.mismatchCount(imagMismatchCount)
	);

	// Read multiplexer; unmapped offsets read as zero
	always @*
	begin
		// Counters and pass flags are read live from the lanes
		case (regAddr)
			`STC_OFF_SEQ_CTRL: next_regRdata = seqCtrlRead;
			`STC_OFF_REAL_ERR: next_regRdata = realMismatchCount;
			`STC_OFF_IMAG_ERR: next_regRdata = imagMismatchCount;
			`STC_OFF_CONST_HI: next_regRdata = constantValueHigh;
			`STC_OFF_CONST_LO: next_regRdata = constantValueLow;
			`STC_OFF_DIGITAL_TEST_CONTROL: next_regRdata = digTestRead;
			`STC_OFF_DECODE: next_regRdata = decoderShuffleControl;
			default: next_regRdata = 8'h00;
		endcase
	end

	// Read answer one clock after the strobe
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			regRdata <= 8'h00;
			regRvalid <= 1'b0;
		end
		else if (ce)
		begin
			regRvalid <= regRead;
			// Read data holds until the next read strobe
			if (regRead)
				regRdata <= next_regRdata;
		end
	end

	// Sample output: the constant replaces both channels while enabled
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			outValid <= 1'b0;
			outReal <= 16'h0000;
			outImag <= 16'h0000;
		end
		else if (ce)
		begin
			// Constant mode forces a valid word every clock
			if (constantTestEnable)
			begin
				outValid <= 1'b1;
				outReal <= constantTestValue;
				outImag <= constantTestValue;
			end
			// Otherwise the stream passes through one register stage
			else
			begin
				outValid <= sampleValid;
				outReal <= realSample;
				outImag <= imagSample;
			end
		end
	end

	// Segment decoder selects: 0 thermometer, 1 shuffled
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			msbShuffle <= 1'b0;
			midShuffle <= 1'b0;
			lsbShuffle <= 1'b0;
		end
		else if (ce)
		begin
			// Registered copies keep every select straight from a flop
			msbShuffle <= decoderShuffleControl[`STC_BIT_MSB_SHUF];
			midShuffle <= decoderShuffleControl[`STC_BIT_MID_SHUF];
			lsbShuffle <= decoderShuffleControl[`STC_BIT_LSB_SHUF];
		end
	end

	// Checker running indication for the rest of the datapath
	always @(posedge clk)
	begin
		if (!nrst)
			checkerActive <= 1'b0;
		else if (ce)
		begin
			// Follows the enable bit, not whether a seed word has arrived
			checkerActive <= checkerEnable;
		end
	end

endmodule

`default_nettype wire

// [hdl/stc_defines.vh]
// Register map, field positions and reset values of the sample path test block.
// Assumes an 8-bit register port with a 12-bit byte address.
`ifndef STC_DEFINES_VH
`define STC_DEFINES_VH

// Register offsets
`define STC_ADDR_W 12
`define STC_OFF_SEQ_CTRL 12'h14b
`define STC_OFF_REAL_ERR 12'h14c
`define STC_OFF_IMAG_ERR 12'h14d
`define STC_OFF_CONST_HI 12'h14e
`define STC_OFF_CONST_LO 12'h14f
`define STC_OFF_DIGITAL_TEST_CONTROL 12'h150
`define STC_OFF_DECODE 12'h151

// Sequence checker control fields
`define STC_BIT_IMAG_PASS 7
`define STC_BIT_REAL_PASS 6
`define STC_BIT_IMAG_INV 4
`define STC_BIT_REAL_INV 3
`define STC_BIT_POLY_SEL 2
`define STC_BIT_CNT_CLEAR 1
`define STC_BIT_CHK_EN 0

// Digital test control fields
`define STC_BIT_CONST_EN 1
`define STC_BIT_DIG_RSVD 0

// Decoder shuffle control fields
`define STC_BIT_MSB_SHUF 2
`define STC_BIT_MID_SHUF 1
`define STC_BIT_LSB_SHUF 0

// Reset values
`define STC_RST_IMAG_INV 1'h1
`define STC_RST_REAL_INV 1'h0
`define STC_RST_BYTE 8'h00
`define STC_RST_COUNT 8'h00

// Polynomial taps counted back from the newest bit
`define STC_TAP7_A 6
`define STC_TAP7_B 7
`define STC_TAP15_A 14
`define STC_TAP15_B 15

`endif

// [hdl/stc_sequence_checker_control_lane.v]
// One channel of the pseudo-random sequence checker: 16 sample bits per clock.
// Assumes samples come from logic on the same clock; bit 15 is the oldest bit.
`default_nettype none
`include "stc_defines.vh"

module stc_sequence_checker_control_lane (
	// Clock and control
	input wire clk,
	input wire nrst,
	input wire ce,
	// Settings
	input wire enable,
	input wire polySel,
	input wire expectInv,
	input wire clearCount,
	// Sample stream
	input wire sampleValid,
	input wire [15:0] sample,
	// Results
	output reg passFlag,
	output reg [7:0] mismatchCount
);

	// Any bit of the newest word that breaks the chosen recurrence
	function stc_word_bad;
		input [31:0] h;
		input poly;
		integer k;
		reg bad;
		begin
			bad = 1'b0;
			for (k = 0; k < 16; k = k + 1)
			begin
				if (poly)
					bad = bad | (h[k] ^ h[k + `STC_TAP15_A] ^ h[k + `STC_TAP15_B]);
				else
					bad = bad | (h[k] ^ h[k + `STC_TAP7_A] ^ h[k + `STC_TAP7_B]);
			end
			stc_word_bad = bad;
		end
	endfunction

	reg [15:0] prevWord;
	reg primed;
	reg errSeen;
	wire [15:0] normWord;
	wire compareNow;
	wire mismatch;

	// Undo the expected inversion before checking
	assign normWord = sample ^ {16{expectInv}};
	assign compareNow = enable & sampleValid & primed;
	assign mismatch = compareNow & stc_word_bad({prevWord, normWord}, polySel);

	// History word and priming; the first word after enable only seeds
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			prevWord <= 16'h0000;
			primed <= 1'b0;
		end
		else if (ce)
		begin
			if (!enable)
				primed <= 1'b0;
			else if (sampleValid)
			begin
				prevWord <= normWord;
				primed <= 1'b1;
			end
		end
	end

	// Counter and pass flag; a mismatch wins over a clear in the same cycle
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			mismatchCount <= `STC_RST_COUNT;
			errSeen <= 1'b0;
			passFlag <= 1'b0;
		end
		else if (ce)
		begin
			if (mismatch)
			begin
				errSeen <= 1'b1;
				passFlag <= 1'b0;
				if (clearCount)
					mismatchCount <= 8'h01;
				else if (mismatchCount != 8'hff)
					mismatchCount <= mismatchCount + 8'h01;
			end
			else if (clearCount)
			begin
				mismatchCount <= `STC_RST_COUNT;
				errSeen <= 1'b0;
				passFlag <= 1'b0;
			end
			else if (compareNow && !errSeen)
				passFlag <= 1'b1;
		end
	end

endmodule

`default_nettype wire

// [verif/stc_src_model.sv]
// Upstream source model: one channel of test samples, bit 15 oldest.
// Assumes the bench raises run and sampleValid together.
`default_nettype none
module stc_src_model (
	// Clock
	input wire logic clk,
	// Controls
	input wire logic run,
	input wire logic poly,
	input wire logic inv,
	input wire logic [15:0] errMask,
	// Sample word
	output logic [15:0] word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] hist = 16'h0001;
	logic [31:0] w;
	// Next word from the last one; idle shows the inverse so nothing stale passes
	always_comb
	begin
		w = {hist, 16'h0000};
		for (int k = 15; k >= 0; k--)
			w[k] = poly ? w[k+14] ^ w[k+15] : w[k+6] ^ w[k+7];
		word = run ? w[15:0] ^ {16{inv}} ^ errMask : ~w[15:0];
	end
	// History moves only on words actually sent
	always @(posedge clk)
		if (run)
			hist <= w[15:0];
endmodule
`default_nettype wire

// [verif/stc_chk.sv]
// Assertions on the ports of the sample path test block.
// Assumes one clock and a synchronous active-low reset taken whatever ce shows.
`default_nettype none
module stc_chk (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Register port
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [11:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic regRvalid,
	// Outputs
	input wire logic outValid,
	input wire logic [15:0] outReal,
	input wire logic [15:0] outImag,
	input wire logic msbShuffle,
	input wire logic midShuffle,
	input wire logic lsbShuffle,
	input wire logic checkerActive
);
	logic [4:0] sh;
	logic [2:0] dec;
	logic constEn;
	logic [15:0] cv;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Mirror of the writable settings
	always @(posedge clk)
		if (!nrst)
		begin
			sh <= 5'h10;
			dec <= 3'h0;
			constEn <= 1'b0;
			cv <= 16'h0000;
		end
		else if (ce && regWrite)
			case (regAddr)
				12'h14b: sh <= regWdata[4:0];
				12'h14e: cv[15:8] <= regWdata;
				12'h14f: cv[7:0] <= regWdata;
				12'h150: constEn <= regWdata[1];
				12'h151: dec <= regWdata[2:0];
				default: ;
			endcase
	sequence s_rd(a);
		ce && regRead && !regWrite && regAddr == a;
	endsequence
	property p_rd;
		ce && regRead |=> regRvalid;
	endproperty
	property p_ctl;
		s_rd(12'h14b) |=> regRdata[5:0] == {1'b0, sh};
	endproperty
	property p_flag;
		s_rd(12'h14b) ##0 sh[1] |=> regRdata[7:6] == 2'b00;
	endproperty
	property p_msb;
		$changed(dec) |-> ##[0:1] msbShuffle == dec[2];
	endproperty
	property p_mid;
		$changed(dec) |-> ##[0:1] midShuffle == dec[1];
	endproperty
	property p_lsb;
		$changed(dec) |-> ##[0:1] lsbShuffle == dec[0];
	endproperty
	property p_act;
		$changed(sh[0]) |-> ##[0:1] checkerActive == sh[0];
	endproperty
	property p_const;
		ce && constEn && $stable(constEn) |=> outValid && outReal == $past(cv) && outImag == $past(cv);
	endproperty
	a_rd: assert property (p_rd) else $error("read answer missing");
	a_ctl: assert property (p_ctl) else $error("control readback wrong");
	a_flag: assert property (p_flag) else $error("pass flag set while cleared");
	a_msb: assert property (p_msb) else $error("top segment select wrong");
	a_mid: assert property (p_mid) else $error("middle segment select wrong");
	a_lsb: assert property (p_lsb) else $error("bottom segment select wrong");
	a_act: assert property (p_act) else $error("checker enable not followed");
	a_const: assert property (p_const) else $error("constant value not sent");
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench: register tasks, two source models and checks.
// Assumes the design, checker and source model are compiled first.
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, ce, regWrite, regRead, sampleValid, run, poly, invR, invI;
	logic [11:0] regAddr;
	logic [7:0] regWdata, regRdata, cfg, expR, expI;
	logic regRvalid, outValid, msbShuffle, midShuffle, lsbShuffle, checkerActive;
	logic [15:0] realSample, imagSample, outReal, outImag, errR, errI;
	int n_fail = 0;
	int total_checks = 0;
	logic [6:0] cases [4] = '{7'b0_10_10_00, 7'b1_01_01_01, 7'b0_11_11_10, 7'b1_00_10_01};
	logic [7:0] resetVals [8] = '{0: 8'h10, default: 8'h00};
	stc_sample_path_test stc_sample_path_test_inst (.clk, .nrst, .ce, .regWrite, .regRead, .regAddr,
		.regWdata, .regRdata, .regRvalid, .sampleValid, .realSample, .imagSample, .outValid, .outReal,
		.outImag, .msbShuffle, .midShuffle, .lsbShuffle, .checkerActive);
	stc_src_model srcReal (.clk, .run, .poly, .inv(invR), .errMask(errR), .word(realSample));
	stc_src_model srcImag (.clk, .run, .poly, .inv(invI), .errMask(errI), .word(imagSample));
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		`CHK(regRdata, e)
	endtask
	// Stream with one corrupted oldest bit at word 5 and a gap at word 9
	task automatic send(input int n, input logic [1:0] e);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			run <= (i != 9);
			sampleValid <= (i != 9);
			errR <= (i == 5 && e[0]) ? 16'h8000 : 16'h0000;
			errI <= (i == 5 && e[1]) ? 16'h8000 : 16'h0000;
		end
		@(posedge clk);
		run <= 1'b0;
		sampleValid <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#40000;
		n_fail++;
		end_of_test();
	end
	// Main sequence
	initial
	begin
		{nrst, regWrite, regRead, sampleValid, run, poly, invR, invI} = '0;
		{regAddr, regWdata, errR, errI} = '0;
		ce = 1'b1;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++)
			rc(12'(12'h14b + i), resetVals[i]);
		wr(12'h14c, 8'hff);
		wr(12'h14d, 8'hff);
		wr(12'h14b, 8'he0);
		rc(12'h14c, 8'h00);
		rc(12'h14d, 8'h00);
		rc(12'h14b, 8'h00);
		// Polynomial, inversion and error cases
		foreach (cases[c])
		begin
			cfg = {3'b000, cases[c][5:4], cases[c][6], 2'b00};
			poly <= cases[c][6];
			{invI, invR} <= cases[c][3:2];
			wr(12'h14b, cfg | 8'h03);
			rc(12'h14b, cfg | 8'h03);
			wr(12'h14b, cfg | 8'h01);
			send(300, cases[c][1:0]);
			expR = (cases[c][4] != cases[c][2]) ? 8'hff : {7'h00, cases[c][0]};
			expI = (cases[c][5] != cases[c][3]) ? 8'hff : {7'h00, cases[c][1]};
			rc(12'h14c, expR);
			rc(12'h14d, expI);
			rc(12'h14b, {expI == 8'h00, expR == 8'h00, 1'b0, cfg[4:0] | 5'h01});
			wr(12'h14b, cfg);
			send(20, 2'b11);
			rc(12'h14c, expR);
			rc(12'h14d, expI);
		end
		wr(12'h14b, 8'h02);
		rc(12'h14c, 8'h00);
		rc(12'h14d, 8'h00);
		rc(12'h14b, 8'h02);
		wr(12'h14b, 8'h00);
		// Constant value mode
		wr(12'h14e, 8'ha5);
		wr(12'h14f, 8'h3c);
		wr(12'h150, 8'hff);
		rc(12'h150, 8'h03);
		`CHK({outValid, outReal, outImag}, {1'b1, 16'ha53c, 16'ha53c})
		wr(12'h150, 8'h00);
		rc(12'h14f, 8'h3c);
		`CHK(outValid, 1'b0)
		// Decoder selects, then a write while ce is low
		for (int d = 0; d < 8; d++)
		begin
			wr(12'h151, 8'(8'ha8 | d));
			rc(12'h151, 8'(8'ha8 | d));
			`CHK({msbShuffle, midShuffle, lsbShuffle}, 3'(d))
		end
		@(posedge clk);
		ce <= 1'b0;
		wr(12'h151, 8'h00);
		ce <= 1'b1;
		rc(12'h151, 8'haf);
		end_of_test();
	end
endmodule
bind stc_sample_path_test stc_chk stc_chk_inst (.clk, .nrst, .ce, .regWrite, .regRead, .regAddr,
	.regWdata, .regRdata, .regRvalid, .outValid, .outReal, .outImag, .msbShuffle, .midShuffle,
	.lsbShuffle, .checkerActive);
`default_nettype wire
